/* File: hw/mer_pkg.sv */
// Constants, types and helpers of the motion error reporting block.
// Assumes a 32-bit APB with byte addresses on 8 bits and eight axes.
// Operation
// - Check program data when program starts
// - Check indirectly supplied data the same way
// - Setting error sets global fault flag
// - Setting error stores faulty program number
// - Setting error stores faulty item code
// - Codes 1 to 999 are low errors
// - Codes 1000 to 1999 are high errors
// - Codes 2000 to 2999 are servo errors
// - Error raises the axis detection signal
// - Separate low, high, servo codes per axis
// - New code overwrites the old one
// - Keep a readable history of errors
// - Hold flags and codes until clear input; code clears setting flag by APB write to OFS_FLAG_CLR
// - Persisting servo fault may set again
// - Axis number is encoded in item code
`default_nettype none
package mer_pkg;
  localparam int NAXIS      = 8;
  localparam int APB_AW     = 8;
  localparam int HIST_DEPTH = 16;
  localparam int HIST_AW    = 4;
  localparam int HIST_W     = 24;
  localparam int IRQ_W      = 3;
  localparam int IRQ_SET    = 0;
  localparam int IRQ_AXIS   = 1;
  localparam int IRQ_AMP    = 2;

  // ********************************
  // Register offsets
  // ********************************
  localparam logic [7:0] OFS_PROG_NUM  = 8'h00;
  localparam logic [7:0] OFS_ITEM      = 8'h04;
  localparam logic [7:0] OFS_FLAGS     = 8'h08;
  localparam logic [7:0] OFS_IRQ_STS   = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MSK   = 8'h10;
  localparam logic [7:0] OFS_FLAG_CLR  = 8'h14;
  localparam logic [7:0] OFS_HIST_SEL  = 8'h18;
  localparam logic [7:0] OFS_HIST_DATA = 8'h1C;
  localparam logic [7:0] OFS_HIST_CNT  = 8'h20;
  localparam logic [7:0] OFS_AXIS_BASE = 8'h40;
  localparam logic [7:0] OFS_AXIS_END  = 8'hC0;
  localparam logic [1:0] SLOT_LOW      = 2'h0;
  localparam logic [1:0] SLOT_HIGH     = 2'h1;
  localparam logic [1:0] SLOT_AMP      = 2'h2;

  // ********************************
  // Reset values
  // ********************************
  localparam logic [15:0]        RST_CODE = 16'h0000;
  localparam logic [IRQ_W-1:0]   RST_IRQ  = 3'h0;
  localparam logic [HIST_AW-1:0] RST_PTR  = 4'h0;
  localparam logic [HIST_AW:0]   RST_CNT  = 5'h00;
  localparam logic [HIST_AW:0]   HIST_FULL = 5'h10;

  // ********************************
  // Error code ranges and data limits
  // ********************************
  localparam logic [15:0] LOW_MIN   = 16'h0001;
  localparam logic [15:0] LOW_MAX   = 16'h03E7;
  localparam logic [15:0] HIGH_MIN  = 16'h03E8;
  localparam logic [15:0] HIGH_MAX  = 16'h07CF;
  localparam logic [15:0] SERVO_MIN = 16'h07D0;
  localparam logic [15:0] SERVO_MAX = 16'h0BB7;
  localparam logic [15:0] PBLK_MIN  = 16'h0001;
  localparam logic [15:0] PBLK_MAX  = 16'h0010;
  localparam logic [15:0] DWELL_MAX = 16'h1388;
  localparam logic [15:0] MCODE_MAX = 16'h00FF;
  localparam logic [15:0] TORQ_MIN  = 16'h0001;
  localparam logic [15:0] TORQ_MAX  = 16'h01F4;
  localparam logic [31:0] VEL_MIN   = 32'h0000_0001;
  localparam logic [31:0] TRAVEL_BAD = 32'h8000_0000;
  localparam logic [15:0] ITEM_NONE  = 16'h0000;
  localparam logic [15:0] ITEM_PBLK  = 16'h0001;
  localparam logic [15:0] ITEM_TRAVEL_SFX = 16'h0003;
  localparam logic [15:0] ITEM_AXIS_MULT  = 16'h0064;
  localparam logic [15:0] ITEM_VEL   = 16'h0004;
  localparam logic [15:0] ITEM_DWELL = 16'h0005;
  localparam logic [15:0] ITEM_MCODE = 16'h0006;
  localparam logic [15:0] ITEM_TORQ  = 16'h0007;

  typedef enum logic [1:0] {
    CLS_NONE  = 2'h0,
    CLS_LOW   = 2'h1,
    CLS_HIGH  = 2'h2,
    CLS_SERVO = 2'h3
  } mer_class_t;

  function automatic mer_class_t mer_classify(input logic [15:0] c);
    if (c >= LOW_MIN && c <= LOW_MAX) return CLS_LOW;
    if (c >= HIGH_MIN && c <= HIGH_MAX) return CLS_HIGH;
    if (c >= SERVO_MIN && c <= SERVO_MAX) return CLS_SERVO;
    return CLS_NONE;
  endfunction

  // Axis 0..7 on the port becomes axis number 1..8 in the code
  function automatic logic [15:0] mer_travel_item(input logic [2:0] ax);
    return 16'(({13'h0000, ax} + 16'h0001) * ITEM_AXIS_MULT + ITEM_TRAVEL_SFX);
  endfunction
endpackage
`default_nettype wire

/* File: hw/mer_hist_if.sv */
// Write and read port of the error history memory.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface mer_hist_if;
  logic                         we;
  logic [mer_pkg::HIST_AW-1:0]  waddr;
  logic [mer_pkg::HIST_W-1:0]   wdata;
  logic [mer_pkg::HIST_AW-1:0]  raddr;
  logic [mer_pkg::HIST_W-1:0]   rdata;
  modport ctl (output we, waddr, wdata, raddr, input rdata);
  modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface
`default_nettype wire

/* File: hw/mer_hist_mem.sv */
// Small error history store with registered read data.
// Assumes the controller tracks which slots hold valid entries.
`timescale 1ns/1ps
`default_nettype none
module mer_hist_mem (
  input wire logic clk,
  input wire logic rst,
  mer_hist_if.mem  hp
);
  import mer_pkg::*;
  logic [HIST_W-1:0] mem_q [HIST_DEPTH];

  always_ff @(posedge clk) begin
    if (hp.we) begin
      mem_q[hp.waddr] <= hp.wdata;
    end
  end

  // Contents are not reset; only the read register is
  always_ff @(posedge clk) begin
    if (rst) begin
      hp.rdata <= '0;
    end else begin
      hp.rdata <= mem_q[hp.raddr];
    end
  end
endmodule // mer_hist_mem
`default_nettype wire

/* File: hw/mer_top.sv */
// Motion error reporting: program data checks, per-axis error codes,
// detection and clear signals, error history, interrupt and APB registers.
// Assumes program and axis error strobes come from logic on MCLK; the
// clear inputs come from pins.
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mer_top (
  input  wire logic                       MCLK,
  input  wire logic                       SYS_RST,
  input  wire logic                       PSEL,
  input  wire logic                       PENABLE,
  input  wire logic                       PWRITE,
  input  wire logic [mer_pkg::APB_AW-1:0] PADDR,
  input  wire logic [31:0]                PWDATA,
  output logic      [31:0]                PRDATA,
  output logic                            PREADY,
  output logic                            PSLVERR,
  input  wire logic                       PROG_START,
  input  wire logic [15:0]                PROG_NUM,
  input  wire logic [2:0]                 PROG_AXIS,
  input  wire logic                       PROG_INCR,
  input  wire logic [31:0]                PROG_TRAVEL,
  input  wire logic [15:0]                PROG_PBLK,
  input  wire logic [31:0]                PROG_VEL,
  input  wire logic [31:0]                VEL_LIMIT,
  input  wire logic [15:0]                PROG_DWELL,
  input  wire logic [15:0]                PROG_MCODE,
  input  wire logic [15:0]                PROG_TORQUE,
  output logic                            PROG_GO,
  output logic                            PROGRAM_SETTING_FAULT_FLAG,
  input  wire logic                       ERR_VALID,
  input  wire logic [2:0]                 ERR_AXIS,
  input  wire logic [15:0]                ERR_CODE,
  input  wire logic [mer_pkg::NAXIS-1:0]  AXIS_FAULT_CLEAR,
  input  wire logic [mer_pkg::NAXIS-1:0]  AXIS_AMP_FAULT_CLEAR,
  output logic      [mer_pkg::NAXIS-1:0]  AXIS_FAULT_DETECT,
  output logic      [mer_pkg::NAXIS-1:0]  AXIS_AMP_FAULT_DETECT,
  output logic                            IRQ
);
  import mer_pkg::*;

  // ********************************
  // Clear input synchronisers
  // ********************************
  logic [NAXIS-1:0] clr_m_q;
  logic [NAXIS-1:0] clr_s_q;
  logic [NAXIS-1:0] aclr_m_q;
  logic [NAXIS-1:0] aclr_s_q;
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      clr_m_q  <= '0;
      clr_s_q  <= '0;
      aclr_m_q <= '0;
      aclr_s_q <= '0;
    end else begin
      clr_m_q  <= AXIS_FAULT_CLEAR;
      clr_s_q  <= clr_m_q;
      aclr_m_q <= AXIS_AMP_FAULT_CLEAR;
      aclr_s_q <= aclr_m_q;
    end
  end

  // ********************************
  // APB handshake
  // ********************************
  logic        access;
  logic        take;
  logic        wr;
  logic        ready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_d;
  logic        map_d;
  logic [7:0]  sub;
  assign access = PSEL && PENABLE;
  assign take   = access && ready_q;
  assign wr     = take && PWRITE;
  // One wait state keeps PRDATA and PREADY straight from flops
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      ready_q   <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      ready_q <= access && !ready_q;
      if (access && !ready_q) begin
        prdata_q  <= PWRITE ? 32'h0000_0000 : rd_d;
        pslverr_q <= !map_d;
      end
    end
  end

  // ********************************
  // Program data check
  // ********************************
  logic [15:0] item_d;
  logic        travel_bad;
  logic        pblk_ok;
  logic        vel_ok;
  logic [15:0] prog_num_q;
  logic [15:0] item_q;
  logic        flag_q;
  logic        go_q;
  logic        flag_clr;
  assign travel_bad = PROG_INCR && (PROG_TRAVEL == TRAVEL_BAD);
  assign pblk_ok    = PROG_PBLK >= PBLK_MIN && PROG_PBLK <= PBLK_MAX;
  assign vel_ok     = PROG_VEL >= VEL_MIN && PROG_VEL <= VEL_LIMIT;
  assign flag_clr   = wr && PADDR == OFS_FLAG_CLR && PWDATA[0];
  // Values set directly or through registers meet the same checks;
  // the program block item wins, then travel, then the lowest item code when several items are bad
  always_comb begin
    item_d = ITEM_NONE;
    if (PROG_TORQUE < TORQ_MIN || PROG_TORQUE > TORQ_MAX) begin
      item_d = ITEM_TORQ;
    end
    if (PROG_MCODE > MCODE_MAX) begin
      item_d = ITEM_MCODE;
    end
    if (PROG_DWELL > DWELL_MAX) begin
      item_d = ITEM_DWELL;
    end
    if (!vel_ok) begin
      item_d = ITEM_VEL;
    end
    if (travel_bad) begin
      item_d = mer_travel_item(PROG_AXIS);
    end
    if (!pblk_ok) begin
      item_d = ITEM_PBLK;
    end
  end

  // Only a bad travel distance blocks the start; others run on defaults
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      go_q <= 1'b0;
    end else begin
      go_q <= PROG_START && !travel_bad;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      prog_num_q <= RST_CODE;
      item_q     <= RST_CODE;
      flag_q     <= 1'b0;
    end else if (PROG_START && item_d != ITEM_NONE) begin
      flag_q     <= 1'b1;
      prog_num_q <= PROG_NUM;
      item_q     <= item_d;
    end else if (flag_clr) begin
      flag_q <= 1'b0;
    end
  end

  // ********************************
  // Per-axis error codes
  // ********************************
  mer_class_t       cls;
  logic [15:0]      low_q  [NAXIS];
  logic [15:0]      high_q [NAXIS];
  logic [15:0]      amp_q  [NAXIS];
  logic             det_q  [NAXIS];
  logic             adet_q [NAXIS];
  logic [NAXIS-1:0] det_v;
  logic [NAXIS-1:0] adet_v;
  assign cls = mer_classify(ERR_CODE);
  for (genvar g = 0; g < NAXIS; g++) begin : g_axis
    logic hit;
    assign hit = ERR_VALID && (ERR_AXIS == 3'(g));
    // A new error in the clear cycle wins over the clear
    always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
        low_q[g]  <= RST_CODE;
        high_q[g] <= RST_CODE;
        det_q[g]  <= 1'b0;
      end else begin
        if (clr_s_q[g]) begin
          low_q[g]  <= RST_CODE;
          high_q[g] <= RST_CODE;
          det_q[g]  <= 1'b0;
        end
        if (hit && cls == CLS_LOW) begin
          low_q[g] <= ERR_CODE;
          det_q[g] <= 1'b1;
        end
        if (hit && cls == CLS_HIGH) begin
          high_q[g] <= ERR_CODE;
          det_q[g]  <= 1'b1;
        end
      end
    end

    // A servo fault still present re-sets the code over the clear
    always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
        amp_q[g]  <= RST_CODE;
        adet_q[g] <= 1'b0;
      end else begin
        if (aclr_s_q[g]) begin
          amp_q[g]  <= RST_CODE;
          adet_q[g] <= 1'b0;
        end
        if (hit && cls == CLS_SERVO) begin
          amp_q[g]  <= ERR_CODE;
          adet_q[g] <= 1'b1;
        end
      end
    end

    assign det_v[g]  = det_q[g];
    assign adet_v[g] = adet_q[g];
  end

  // ********************************
  // Error history
  // ********************************
  mer_hist_if                hif ();
  logic [HIST_AW-1:0]        wptr_q;
  logic [HIST_AW:0]          cnt_q;
  logic [HIST_AW-1:0]        sel_q;
  assign hif.we    = ERR_VALID && cls != CLS_NONE;
  assign hif.waddr = wptr_q;
  assign hif.wdata = {ERR_AXIS, 3'h0, cls, ERR_CODE};
  assign hif.raddr = sel_q;
  // Oldest entries are overwritten once the store is full
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      wptr_q <= RST_PTR;
      cnt_q  <= RST_CNT;
    end else if (hif.we) begin
      wptr_q <= wptr_q + 4'h1;
      if (cnt_q != HIST_FULL) begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      sel_q <= RST_PTR;
    end else if (wr && PADDR == OFS_HIST_SEL) begin
      sel_q <= PWDATA[HIST_AW-1:0];
    end
  end

  mer_hist_mem u_hist (
    .clk (MCLK),
    .rst (SYS_RST),
    .hp  (hif.mem)
  );

  // ********************************
  // Interrupt
  // ********************************
  logic [IRQ_W-1:0] sts_q;
  logic [IRQ_W-1:0] msk_q;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] w1c;
  logic             irq_q;
  assign ev[IRQ_SET]  = PROG_START && item_d != ITEM_NONE;
  assign ev[IRQ_AXIS] = ERR_VALID && (cls == CLS_LOW || cls == CLS_HIGH);
  assign ev[IRQ_AMP]  = ERR_VALID && cls == CLS_SERVO;
  assign w1c = (wr && PADDR == OFS_IRQ_STS) ? PWDATA[IRQ_W-1:0] : RST_IRQ;
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      sts_q <= RST_IRQ;
      msk_q <= RST_IRQ;
      irq_q <= 1'b0;
    end else begin
      sts_q <= (sts_q & ~w1c) | ev;
      if (wr && PADDR == OFS_IRQ_MSK) begin
        msk_q <= PWDATA[IRQ_W-1:0];
      end
      irq_q <= |(sts_q & msk_q);
    end
  end

  // ********************************
  // Read decode
  // ********************************
  always_comb begin
    rd_d  = 32'h0000_0000;
    map_d = 1'b1;
    sub   = PADDR - OFS_AXIS_BASE;
    if (PADDR[1:0] != 2'h0) begin
      map_d = 1'b0;
    end else if (PADDR >= OFS_AXIS_BASE && PADDR < OFS_AXIS_END) begin
      case (sub[3:2])
        SLOT_LOW:  rd_d = {16'h0000, low_q[sub[6:4]]};
        SLOT_HIGH: rd_d = {16'h0000, high_q[sub[6:4]]};
        SLOT_AMP:  rd_d = {16'h0000, amp_q[sub[6:4]]};
        default:   map_d = 1'b0;
      endcase
    end else begin
      case (PADDR)
        OFS_PROG_NUM:  rd_d = {16'h0000, prog_num_q};
        OFS_ITEM:      rd_d = {16'h0000, item_q};
        OFS_FLAGS:     rd_d = {8'h00, adet_v, det_v, 7'h00, flag_q};
        OFS_IRQ_STS:   rd_d = {29'h0000_0000, sts_q};
        OFS_IRQ_MSK:   rd_d = {29'h0000_0000, msk_q};
        OFS_FLAG_CLR:  rd_d = 32'h0000_0000;
        OFS_HIST_SEL:  rd_d = {28'h000_0000, sel_q};
        OFS_HIST_DATA: rd_d = ({1'b0, sel_q} < cnt_q) ? {8'h00, hif.rdata} : 32'h0000_0000;
        OFS_HIST_CNT:  rd_d = {27'h000_0000, cnt_q};
        default:       map_d = 1'b0;
      endcase
    end
  end

  assign PRDATA                     = prdata_q;
  assign PREADY                     = ready_q;
  assign PSLVERR                    = pslverr_q;
  assign PROG_GO                    = go_q;
  assign PROGRAM_SETTING_FAULT_FLAG = flag_q;
  assign AXIS_FAULT_DETECT          = det_v;
  assign AXIS_AMP_FAULT_DETECT      = adet_v;
  assign IRQ                        = irq_q;

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  travel_block_a: assert property (PROG_START && travel_bad |=> !PROG_GO)
    else $error("start not blocked on bad travel");
  mcode_check_a: assert property (PROG_START && PROG_MCODE > MCODE_MAX
      |=> PROGRAM_SETTING_FAULT_FLAG && item_q != ITEM_NONE)
    else $error("m code error missed");
  set_flag_a: assert property (PROG_START && item_d != ITEM_NONE
      |=> PROGRAM_SETTING_FAULT_FLAG ##1 PROGRAM_SETTING_FAULT_FLAG || $past(flag_clr))
    else $error("setting flag not set");
  prog_num_a: assert property (PROG_START && item_d != ITEM_NONE
      |=> prog_num_q == $past(PROG_NUM))
    else $error("program number not stored");
  dwell_item_a: assert property (PROG_START && PROG_DWELL > DWELL_MAX && pblk_ok
      && vel_ok && !travel_bad |=> item_q == ITEM_DWELL)
    else $error("dwell item code wrong");
  low_store_a: assert property (ERR_VALID && cls == CLS_LOW
      |=> low_q[$past(ERR_AXIS)] == $past(ERR_CODE) && det_v[$past(ERR_AXIS)])
    else $error("low error not stored");
  high_store_a: assert property (ERR_VALID && ERR_CODE >= HIGH_MIN && ERR_CODE <= HIGH_MAX
      |=> high_q[$past(ERR_AXIS)] == $past(ERR_CODE))
    else $error("high error not stored");
  servo_store_a: assert property (ERR_VALID && ERR_CODE >= SERVO_MIN
      && ERR_CODE <= SERVO_MAX |=> amp_q[$past(ERR_AXIS)] == $past(ERR_CODE)
      && adet_v[$past(ERR_AXIS)])
    else $error("servo error not stored");
  det_hold_a: assert property (($past(det_v) & ~$past(clr_s_q) & ~det_v) == 8'h00)
    else $error("detect dropped without clear");
  clr_local_a: assert property (clr_s_q != 8'h00 && !ERR_VALID
      |=> (det_v & $past(clr_s_q)) == 8'h00
      && (det_v & ~$past(clr_s_q)) == ($past(det_v) & ~$past(clr_s_q)))
    else $error("clear reached other axis");
  travel_code_a: assert property (PROG_START && travel_bad && pblk_ok
      |=> item_q == mer_travel_item($past(PROG_AXIS)))
    else $error("axis not encoded in item");
  hist_count_a: assert property (hif.we && cnt_q != HIST_FULL
      |=> cnt_q == $past(cnt_q) + 5'h01)
    else $error("history not counted");
  reset_zero_a: assert property (disable iff (1'b0) SYS_RST
      |=> det_v == 8'h00 && adet_v == 8'h00 && !IRQ && !PROGRAM_SETTING_FAULT_FLAG)
    else $error("state not zero after reset");
  setting_err_c: cover property (PROG_START && item_d != ITEM_NONE);
  servo_clear_c: cover property (ERR_VALID && cls == CLS_SERVO ##[1:40] aclr_s_q != 8'h00);
  irq_raise_c:   cover property (!IRQ ##1 IRQ);
endmodule // mer_top
`default_nettype wire

/* File: sim/mer_cpu_model.sv */
// Model of the sequence processor side that reports axis errors.
// Assumes one clock shared with the block and a pulse per report.
`timescale 1ns/1ps
`default_nettype none
module mer_cpu_model (
  input  wire logic        clk,
  input  wire logic        fire,
  input  wire logic        hold,
  input  wire logic [2:0]  ax,
  input  wire logic [15:0] code,
  output logic             valid,
  output logic [2:0]       err_axis,
  output logic [15:0]      err_code
);
  // ********************************
  // Report lines
  // ********************************
  logic [2:0]  ax_q   = 3'h0;
  logic [15:0] code_q = 16'h0000;

  initial valid = 1'b0;

  // A servo fault that persists is reported again every cycle until
  // its cause is removed, which the bench does while the clear is still held
  always @(posedge clk) begin
    valid <= fire | hold;
    if (fire) begin
      ax_q <= ax;
      code_q <= code;
    end
  end

  // Idle lines carry the inverse so a stale value never matches
  assign err_axis = valid ? ax_q : ~ax_q;
  assign err_code = valid ? code_q : ~code_q;
endmodule // mer_cpu_model
`default_nettype wire

/* File: sim/motion_error_reporting_test.sv */
// Self-checking bench of the motion error reporting block.
// Assumes the partner model file and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module motion_error_reporting_test;
  import mer_pkg::*;
  logic        MCLK = 1'b0, SYS_RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic        PROG_START = 1'b0, PROG_INCR = 1'b1, fire = 1'b0, hold = 1'b0;
  logic [2:0]  PROG_AXIS = 3'h0, ax_in = 3'h0;
  logic [7:0]  PADDR = 8'h00, AXIS_FAULT_CLEAR = 8'h00, AXIS_AMP_FAULT_CLEAR = 8'h00;
  logic [15:0] PROG_NUM = 16'h0000, PROG_PBLK = 16'h0001, PROG_DWELL = 16'h0000;
  logic [15:0] PROG_MCODE = 16'h0000, PROG_TORQUE = 16'h0001, code_in = 16'h0000;
  logic [31:0] PWDATA = 32'h0000_0000, PROG_TRAVEL = 32'h0000_0005;
  logic [31:0] PROG_VEL = 32'h0000_000A, VEL_LIMIT = 32'h0000_0064;
  logic [31:0] PRDATA;
  logic        PREADY, PSLVERR, PROG_GO, PROGRAM_SETTING_FAULT_FLAG, ERR_VALID, IRQ;
  logic [2:0]  ERR_AXIS;
  logic [15:0] ERR_CODE;
  logic [7:0]  AXIS_FAULT_DETECT, AXIS_AMP_FAULT_DETECT;
  logic [32:0] expq[$];
  logic [15:0] lo[8], hi[8], sv[8], lfsr = 16'h003C, pnum = 16'h0000;
  logic [15:0] codes[8] = '{16'h0001, 16'h03E7, 16'h03E8, 16'h07CF,
                            16'h07D0, 16'h0BB7, 16'h0BB8, 16'h0000};
  logic [7:0]  det = 8'h00, amp = 8'h00;
  logic [2:0]  stat = 3'h0;
  logic [23:0] first_ent = 24'h00_0000;
  int          err_total = 0, tests_run = 0, cyc = 0, nhist = 0;

  always #2 MCLK = ~MCLK;

  mer_top u_dut (.MCLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .PROG_START, .PROG_NUM, .PROG_AXIS, .PROG_INCR, .PROG_TRAVEL,
    .PROG_PBLK, .PROG_VEL, .VEL_LIMIT, .PROG_DWELL, .PROG_MCODE, .PROG_TORQUE, .PROG_GO,
    .PROGRAM_SETTING_FAULT_FLAG, .ERR_VALID, .ERR_AXIS, .ERR_CODE, .AXIS_FAULT_CLEAR,
    .AXIS_AMP_FAULT_CLEAR, .AXIS_FAULT_DETECT, .AXIS_AMP_FAULT_DETECT, .IRQ);

  mer_cpu_model u_cpu (.clk(MCLK), .fire(fire), .hold(hold), .ax(ax_in), .code(code_in),
    .valid(ERR_VALID), .err_axis(ERR_AXIS), .err_code(ERR_CODE));

  // ********************************
  // Helpers
  // ********************************
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    tests_run++;
    if (seen !== want) begin
      err_total++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic end_sim();
    if (err_total == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Request held until the edge that samples ready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do @(posedge MCLK); while (PREADY !== 1'b1);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic e = 1'b0);
    expq.push_back({e, v});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic rax(input logic [2:0] ax);
    rd(OFS_AXIS_BASE + {ax, 4'h0}, {16'h0000, lo[ax]});
    rd(OFS_AXIS_BASE + {ax, 4'h4}, {16'h0000, hi[ax]});
    rd(OFS_AXIS_BASE + {ax, 4'h8}, {16'h0000, sv[ax]});
  endtask

  task automatic prog(input int k, input logic [2:0] ax, input logic [15:0] num);
    logic [15:0] item;
    item = (k == 2) ? 16'((int'(ax) + 1) * 100 + 3) : 16'((k == 7) ? 7 : (k > 2) ? k + 1 : k);
    if (k != 0 && k != 7) pnum = num;
    @(posedge MCLK);
    PROG_AXIS <= ax;
    PROG_NUM <= num;
    // Case 7: absolute move, so the incremental-only travel limit must not fire
    PROG_INCR <= (k != 7);
    PROG_PBLK <= (k == 1) ? 16'h0011 : 16'h0001;
    PROG_TRAVEL <= (k == 2 || k == 7) ? 32'h8000_0000 : 32'h0000_0005;
    PROG_VEL <= (k == 3) ? 32'h0000_0065 : 32'h0000_0064;
    PROG_DWELL <= (k == 4) ? 16'h1389 : 16'h1388;
    PROG_MCODE <= (k == 5) ? 16'h0100 : 16'h00FF;
    PROG_TORQUE <= (k == 6) ? 16'h0000 : 16'h01F4;
    PROG_START <= 1'b1;
    @(posedge MCLK);
    PROG_START <= 1'b0;
    @(negedge MCLK);
    check(PROG_GO, k != 2);
    check(PROGRAM_SETTING_FAULT_FLAG, k != 0);
    if (k != 0) stat[0] = 1'b1;
    rd(OFS_ITEM, {16'h0000, item});
    rd(OFS_PROG_NUM, {16'h0000, pnum});
  endtask

  task automatic err(input logic [2:0] ax, input logic [15:0] c);
    logic [1:0] cls;
    cls = 2'h0;
    @(posedge MCLK);
    ax_in <= ax;
    code_in <= c;
    fire <= 1'b1;
    @(posedge MCLK);
    fire <= 1'b0;
    if (c >= 1 && c <= 999) begin
      lo[ax] = c;
      det[ax] = 1'b1;
      cls = 2'h1;
    end else if (c >= 1000 && c <= 1999) begin
      hi[ax] = c;
      det[ax] = 1'b1;
      cls = 2'h2;
    end else if (c >= 2000 && c <= 2999) begin
      sv[ax] = c;
      amp[ax] = 1'b1;
      cls = 2'h3;
    end
    if (cls != 2'h0) begin
      stat[(cls == 2'h3) ? 2 : 1] = 1'b1;
      if (nhist == 0) first_ent = {ax, 3'h0, cls, c};
      nhist++;
    end
    repeat (2) @(posedge MCLK);
    check(AXIS_FAULT_DETECT, det);
    check(AXIS_AMP_FAULT_DETECT, amp);
  endtask

  // ********************************
  // Read monitor and time limit
  // ********************************
  always @(posedge MCLK) begin
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE) check({PSLVERR, PRDATA}, expq.pop_front());
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_sim();
    end
  end

  initial begin
    logic [15:0] r;
    foreach (lo[i]) begin
      lo[i] = 16'h0000;
      hi[i] = 16'h0000;
      sv[i] = 16'h0000;
    end
    repeat (5) @(posedge MCLK);
    SYS_RST <= 1'b0;
    @(negedge MCLK);
    check({PROG_GO, PROGRAM_SETTING_FAULT_FLAG, IRQ, AXIS_FAULT_DETECT, AXIS_AMP_FAULT_DETECT},
          33'h0_0000_0000);
    for (int a = 0; a < 8; a++) rax(3'(a));
    rd(OFS_HIST_CNT, 32'h0000_0000);
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      prog(k, r[2:0], r);
    end
    rd(OFS_FLAGS, 32'h0000_0001);
    apb(1'b1, OFS_FLAG_CLR, 32'h0000_0001);
    rd(OFS_FLAGS, 32'h0000_0000);
    apb(1'b1, OFS_AXIS_BASE, 32'h0000_FFFF);
    rd(8'h4C, 32'h0000_0000, 1'b1);
    rd(8'h02, 32'h0000_0000, 1'b1);
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      err(r[2:0], codes[r[5:3]]);
      rax(r[2:0]);
    end
    rd(OFS_HIST_CNT, 32'(nhist));
    apb(1'b1, OFS_HIST_SEL, 32'h0000_0000);
    rd(OFS_HIST_DATA, {8'h00, first_ent});
    err(3'h2, 16'h0007);
    err(3'h2, 16'h03E8);
    err(3'h3, 16'h0010);
    AXIS_FAULT_CLEAR <= 8'h04;
    repeat (5) @(posedge MCLK);
    AXIS_FAULT_CLEAR <= 8'h00;
    lo[2] = 16'h0000;
    hi[2] = 16'h0000;
    det[2] = 1'b0;
    check(AXIS_FAULT_DETECT, det);
    check(AXIS_AMP_FAULT_DETECT, amp);
    rax(3'h2);
    rax(3'h3);
    check(IRQ, 1'b0);
    rd(OFS_IRQ_STS, 32'(stat));
    apb(1'b1, OFS_IRQ_MSK, 32'h0000_0007);
    repeat (3) @(posedge MCLK);
    check(IRQ, |stat);
    apb(1'b1, OFS_IRQ_STS, 32'h0000_0007);
    repeat (3) @(posedge MCLK);
    check(IRQ, 1'b0);
    rd(OFS_IRQ_STS, 32'h0000_0000);
    err(3'h5, 16'h09C4);
    hold <= 1'b1;
    AXIS_AMP_FAULT_CLEAR <= 8'h20;
    repeat (6) @(posedge MCLK);
    check(AXIS_AMP_FAULT_DETECT, amp);
    hold <= 1'b0;
    repeat (5) @(posedge MCLK);
    AXIS_AMP_FAULT_CLEAR <= 8'h00;
    sv[5] = 16'h0000;
    amp[5] = 1'b0;
    check(AXIS_AMP_FAULT_DETECT, amp);
    rax(3'h5);
    repeat (4) @(posedge MCLK);
    end_sim();
  end
endmodule // motion_error_reporting_test
`default_nettype wire
